// [hdl/faos_regs.svh]
// register map, field positions, reset values and codes of the output block
`ifndef FAOS_REGS_SVH
`define FAOS_REGS_SVH
// ======================================================================
// channels and address decode
`define FAOS_NCH 2
`define FAOS_CH_BIT 5
`define FAOS_IDX_HI 4
`define FAOS_IDX_LO 2
`define FAOS_MAP_HI 31
`define FAOS_MAP_LO 6
`define FAOS_BYTES 4
// ======================================================================
// register index within a channel, byte address is four times the index
`define FAOS_IDX_CFG 3'h0
`define FAOS_IDX_THR 3'h1
`define FAOS_IDX_LOW 3'h2
`define FAOS_IDX_HYS 3'h3
`define FAOS_IDX_ASTART 3'h4
`define FAOS_IDX_AEND 3'h5
`define FAOS_IDX_STAT 3'h6
`define FAOS_IDX_CODE 3'h7
// ======================================================================
// configuration word layout and reset value
`define FAOS_CFG_HI 19
`define FAOS_CFG_RST 20'h00E00
`define FAOS_DIR_HIGH 0
`define FAOS_DIR_DOWN 1
// ======================================================================
// bus responses
`define FAOS_OKAY 2'h0
`define FAOS_SLVERR 2'h2
// ======================================================================
// analogue codes: full scale, live zero (4 mA of 20, 2 V of 10), zero
`define FAOS_CODE_FS 16'hFFFF
`define FAOS_CODE_LIVE 16'h3333
`define FAOS_CODE_ZERO 16'h0000
`endif

// [hdl/faos_pkg.sv]
// types of the flow alarm and output scaling block
package faos_pkg;
  `include "faos_regs.svh"
  // ======================================================================
  // selectors
  typedef enum logic [1:0] {
    FAOS_FLOW = 2'h0, FAOS_VOLUME = 2'h1, FAOS_TEMP = 2'h2, FAOS_PART = 2'h3
  } faos_src_e;
  typedef enum logic [3:0] {
    FAOS_T4_20 = 4'h0, FAOS_T0_20 = 4'h1, FAOS_T0_10 = 4'h2, FAOS_T2_10 = 4'h3,
    FAOS_T_ALARM = 4'h4, FAOS_T_PULSE = 4'h5, FAOS_T_FREQ = 4'h6,
    FAOS_T_LINK = 4'h7, FAOS_T_CTRL = 4'h8
  } faos_type_e;
  typedef enum logic {FAOS_LIMIT = 1'h0, FAOS_WINDOW = 1'h1} faos_mode_e;
  typedef enum logic {FAOS_NO = 1'h0, FAOS_NC = 1'h1} faos_pol_e;
  typedef enum logic [1:0] {
    FAOS_SINKING_DRIVE = 2'h0, FAOS_SOURCING_DRIVE = 2'h1, FAOS_PUSH_PULL_DRIVE = 2'h2
  } faos_drive_e;
  // ======================================================================
  // carriers and state
  typedef struct packed {
    logic [7:0] debounceSampleCount;
    logic [1:0] dir;
    faos_drive_e drive;
    faos_pol_e pol;
    faos_mode_e mode;
    faos_type_e typ;
    faos_src_e src;
  } faos_cfg_s;
  typedef struct packed {
    logic signed [31:0] flow;
    logic signed [31:0] volume;
    logic signed [31:0] temp;
    logic signed [31:0] part;
  } faos_meas_s;
  typedef struct packed {
    faos_cfg_s cfg;
    logic signed [31:0] thr;
    logic signed [31:0] low;
    logic [31:0] hyst;
    logic signed [31:0] aStart;
    logic signed [31:0] aEnd;
    logic [7:0] cnt;
    logic alarm;
    logic badSrc;
    logic on;
    logic srcEn;
    logic snkEn;
    logic [15:0] code;
  } faos_chan_s;
  typedef struct packed {
    faos_chan_s [`FAOS_NCH-1:0] ch;
    logic awRdy;
    logic wRdy;
    logic awHeld;
    logic wHeld;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arRdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } faos_state_s;
endpackage

// [hdl/faos_top.sv]
// two-channel alarm and analogue scaling outputs with an AXI4-Lite slave
// Summary of operation
// - two output channels, each with its own independent configuration
// - each channel picks flow, volume, temperature or partial volume as source
// - type selector: 4-20mA, 0-20mA, 0-10V, 2-10V, alarm, pulse, freq, link, control
// - limit: assert above threshold, release below threshold minus hysteresis
// - window: assert when value lies outside lower to upper threshold band
// - window band edges both pulled inward by the hysteresis amount
// - normally open switches on above threshold, normally closed the reverse
// - inverted polarity in window mode asserts while value lies inside band
// - lower threshold has no effect in limit mode
// - thresholds are signed and compare correctly for negative values
// - alarm drive mode: sinking only, sourcing only or push-pull
// - debounce count above one delays switching, zero or one gives no delay
// - direction chooses delay on rising, falling or both alarm changes
// - alarm changes only after count consecutive samples on the new side
// - current and voltage outputs accept only flow or temperature
// - current maps start value to 4 or 0 mA, full scale to 20 mA
// - current full scale defaults to range end, accepted only above range start
// - current start value settable anywhere within the measuring range
// - voltage maps start value to 0 or 2 V, full scale to 10 V
// - voltage full scale defaults to range end, must exceed range start
// - voltage start value settable anywhere within the measuring range
// - factory full-scale end values equal the measuring range full scale
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module faos_top
  import faos_pkg::*;
#(
  parameter logic signed [31:0] RANGE_START = 32'sh00000000,
  parameter logic signed [31:0] RANGE_END = 32'sh000003E8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // measurement update
  input wire logic sampleStb,
  input wire faos_meas_s meas,
  // axi4-lite write
  input wire logic awvalid,
  input wire logic [31:0] awaddr,
  output logic awready,
  input wire logic wvalid,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic wready,
  output logic bvalid,
  output logic [1:0] bresp,
  input wire logic bready,
  // axi4-lite read
  input wire logic arvalid,
  input wire logic [31:0] araddr,
  output logic arready,
  output logic rvalid,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rready,
  // channel outputs
  output logic [`FAOS_NCH-1:0] alarmOn,
  output logic [`FAOS_NCH-1:0] sinkEn,
  output logic [`FAOS_NCH-1:0] sourceEn,
  output logic [`FAOS_NCH-1:0][15:0] analogCode
);

  // ======================================================================
  // elaboration check
  if (RANGE_END <= RANGE_START) begin : g_chk
    $error("range end must exceed range start");
  end

  faos_state_s s;
  faos_state_s n;
  logic [`FAOS_NCH-1:0] wantA;
  logic [`FAOS_NCH-1:0] applyA;
  logic signed [31:0] vSelA [`FAOS_NCH];

  // ======================================================================
  // helpers
  // pick the measured quantity of a channel
  function automatic logic signed [31:0] pickSrc(faos_src_e src, faos_meas_s m);
    pickSrc = m.flow;
    unique case (src)
      FAOS_FLOW: pickSrc = m.flow;
      FAOS_VOLUME: pickSrc = m.volume;
      FAOS_TEMP: pickSrc = m.temp;
      FAOS_PART: pickSrc = m.part;
    endcase
  endfunction

  // wanted alarm state, widened so threshold minus hysteresis cannot wrap
  function automatic logic alarmWant(faos_cfg_s c, logic signed [31:0] v, logic signed [31:0] t,
                                     logic signed [31:0] l, logic [31:0] h, logic cur);
    logic signed [33:0] vx;
    logic signed [33:0] tx;
    logic signed [33:0] lx;
    logic signed [33:0] hx;
    vx = 34'(v);
    tx = 34'(t);
    lx = 34'(l);
    hx = $signed({2'h0, h});
    if (c.mode == FAOS_LIMIT)
      alarmWant = cur ? !(vx < tx - hx) : (vx > tx);
    else
      alarmWant = cur ? !(vx > lx + hx && vx < tx - hx) : (vx > tx || vx < lx);
  endfunction

  // linear map onto the output code, ends clamped
  function automatic logic [15:0] scaleCode(logic signed [31:0] v, logic signed [31:0] st,
                                            logic signed [31:0] en, logic [15:0] lo);
    logic [32:0] num;
    logic [32:0] den;
    logic [48:0] q;
    num = '0;
    den = '0;
    q = '0;
    scaleCode = lo;
    if (v >= en) begin
      scaleCode = `FAOS_CODE_FS;
    end else if (v > st) begin
      num = 33'(v) - 33'(st);
      den = 33'(en) - 33'(st);
      q = (49'(num) * 49'(`FAOS_CODE_FS - lo)) / 49'(den);
      scaleCode = lo + q[15:0];
    end
  endfunction

  // register read mux
  function automatic logic [31:0] rdReg(faos_state_s st, logic [31:0] a);
    faos_chan_s c;
    c = st.ch[a[`FAOS_CH_BIT]];
    rdReg = '0;
    unique case (a[`FAOS_IDX_HI:`FAOS_IDX_LO])
      `FAOS_IDX_CFG: rdReg = 32'(c.cfg);
      `FAOS_IDX_THR: rdReg = c.thr;
      `FAOS_IDX_LOW: rdReg = c.low;
      `FAOS_IDX_HYS: rdReg = c.hyst;
      `FAOS_IDX_ASTART: rdReg = c.aStart;
      `FAOS_IDX_AEND: rdReg = c.aEnd;
      `FAOS_IDX_STAT: rdReg = 32'({c.badSrc, c.alarm});
      `FAOS_IDX_CODE: rdReg = 32'(c.code);
    endcase
  endfunction

  // ======================================================================
  // next state
  always_comb begin
    logic [31:0] mask;
    logic [31:0] merged;
    logic chSel;
    faos_cfg_s c;
    logic [15:0] lo;
    mask = '0;
    merged = '0;
    chSel = 1'b0;
    c = faos_cfg_s'(`FAOS_CFG_RST);
    lo = `FAOS_CODE_ZERO;
    n = s;
    wantA = '0;
    applyA = '0;
    for (int i = 0; i < `FAOS_NCH; i++) begin
      vSelA[i] = '0;
    end
    // write address and data taken in either order
    if (awvalid && s.awRdy) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && s.wRdy) begin
      n.wHeld = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    // perform the write once both halves are held
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `FAOS_OKAY;
      for (int b = 0; b < `FAOS_BYTES; b++) begin
        mask[b*8+:8] = {8{s.wStrb[b]}};
      end
      merged = (rdReg(s, s.awAddr) & ~mask) | (s.wData & mask);
      chSel = s.awAddr[`FAOS_CH_BIT];
      if (s.awAddr[`FAOS_MAP_HI:`FAOS_MAP_LO] != '0) begin
        n.bresp = `FAOS_SLVERR;
      end else begin
        unique case (s.awAddr[`FAOS_IDX_HI:`FAOS_IDX_LO])
          `FAOS_IDX_CFG: n.ch[chSel].cfg = faos_cfg_s'(merged[`FAOS_CFG_HI:0]);
          `FAOS_IDX_THR: n.ch[chSel].thr = merged;
          `FAOS_IDX_LOW: n.ch[chSel].low = merged;
          `FAOS_IDX_HYS: n.ch[chSel].hyst = merged;
          `FAOS_IDX_ASTART: begin
            if ($signed(merged) >= RANGE_START && $signed(merged) <= RANGE_END) begin
              n.ch[chSel].aStart = merged;
            end
          end
          `FAOS_IDX_AEND: begin
            if ($signed(merged) > RANGE_START) begin
              n.ch[chSel].aEnd = merged;
            end
          end
          `FAOS_IDX_STAT, `FAOS_IDX_CODE: begin
          end
        endcase
      end
    end
    n.awRdy = !n.awHeld && !n.bvalid;
    n.wRdy = !n.wHeld && !n.bvalid;
    // read channel, one read in flight
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arRdy) begin
      n.rvalid = 1'b1;
      n.rdata = rdReg(s, araddr);
      n.rresp = `FAOS_OKAY;
      if (araddr[`FAOS_MAP_HI:`FAOS_MAP_LO] != '0) begin
        n.rdata = '0;
        n.rresp = `FAOS_SLVERR;
      end
    end
    n.arRdy = !n.rvalid;
    // per channel alarm decision, debounce and scaling
    for (int i = 0; i < `FAOS_NCH; i++) begin
      c = s.ch[i].cfg;
      vSelA[i] = pickSrc(c.src, meas);
      wantA[i] = alarmWant(c, vSelA[i], s.ch[i].thr, s.ch[i].low, s.ch[i].hyst, s.ch[i].alarm);
      applyA[i] = wantA[i] ? c.dir[`FAOS_DIR_HIGH] : c.dir[`FAOS_DIR_DOWN];
      if (sampleStb) begin
        if (wantA[i] == s.ch[i].alarm) begin
          n.ch[i].cnt = '0;
        end else if (!applyA[i] || 9'(s.ch[i].cnt) + 9'h001 >= 9'(c.debounceSampleCount)) begin
          n.ch[i].alarm = wantA[i];
          n.ch[i].cnt = '0;
        end else begin
          n.ch[i].cnt = s.ch[i].cnt + 8'h01;
        end
        lo = (c.typ == FAOS_T4_20 || c.typ == FAOS_T2_10) ? `FAOS_CODE_LIVE : `FAOS_CODE_ZERO;
        n.ch[i].badSrc = 1'b0;
        n.ch[i].code = `FAOS_CODE_ZERO;
        if (c.typ <= FAOS_T2_10) begin
          if (c.src == FAOS_FLOW || c.src == FAOS_TEMP) begin
            n.ch[i].code = scaleCode(vSelA[i], s.ch[i].aStart, s.ch[i].aEnd, lo);
          end else begin
            n.ch[i].badSrc = 1'b1;
          end
        end
      end
      // polarity and drive stage from the next state
      n.ch[i].on = n.ch[i].alarm ^ (n.ch[i].cfg.pol == FAOS_NC);
      n.ch[i].srcEn = 1'b0;
      n.ch[i].snkEn = 1'b0;
      if (n.ch[i].cfg.typ == FAOS_T_ALARM) begin
        if (n.ch[i].cfg.drive == FAOS_SINKING_DRIVE) begin
          n.ch[i].snkEn = n.ch[i].on;
        end else if (n.ch[i].cfg.drive == FAOS_SOURCING_DRIVE) begin
          n.ch[i].srcEn = n.ch[i].on;
        end else if (n.ch[i].cfg.drive == FAOS_PUSH_PULL_DRIVE) begin
          n.ch[i].srcEn = n.ch[i].on;
          n.ch[i].snkEn = !n.ch[i].on;
        end
      end
    end
  end

  // ======================================================================
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      for (int k = 0; k < `FAOS_NCH; k++) begin
        s.ch[k].cfg <= faos_cfg_s'(`FAOS_CFG_RST);
        s.ch[k].aStart <= RANGE_START;
        s.ch[k].aEnd <= RANGE_END;
      end
      s.awRdy <= 1'b1;
      s.wRdy <= 1'b1;
      s.arRdy <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ======================================================================
  // outputs straight from the state register
  assign awready = s.awRdy;
  assign wready = s.wRdy;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arRdy;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  for (genvar g = 0; g < `FAOS_NCH; g++) begin : g_out
    assign alarmOn[g] = s.ch[g].on;
    assign sinkEn[g] = s.ch[g].snkEn;
    assign sourceEn[g] = s.ch[g].srcEn;
    assign analogCode[g] = s.ch[g].code;
  end

  // ======================================================================
  // checks
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // bus response held until taken
  AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  // read answered one cycle after the address is taken
  AST_READ_NEXT: assert property (arvalid && arready |=> rvalid ##0 !arready)
    else $error("read not answered");

  for (genvar i = 0; i < `FAOS_NCH; i++) begin : g_chk_ch
    // sinking drive never sources and follows the alarm
    AST_DRV_SINK: assert property (
      s.ch[i].cfg.typ == FAOS_T_ALARM && s.ch[i].cfg.drive == FAOS_SINKING_DRIVE
      |-> !sourceEn[i] && sinkEn[i] == alarmOn[i])
      else $error("sinking drive wrong");
    // push-pull drives exactly one level
    AST_DRV_PP: assert property (
      s.ch[i].cfg.typ == FAOS_T_ALARM && s.ch[i].cfg.drive == FAOS_PUSH_PULL_DRIVE
      |-> sourceEn[i] == alarmOn[i] && sinkEn[i] != alarmOn[i])
      else $error("push-pull drive wrong");
    // output equals state, inverted when normally closed
    AST_POLARITY: assert property (
      alarmOn[i] == (s.ch[i].alarm ^ (s.ch[i].cfg.pol == FAOS_NC)))
      else $error("polarity wrong");
    // zero count switches on the first sample
    AST_NO_DELAY: assert property (
      sampleStb && s.ch[i].cfg.debounceSampleCount == 8'h00 && wantA[i] != s.ch[i].alarm
      |=> s.ch[i].alarm != $past(s.ch[i].alarm))
      else $error("undelayed switch missed");
    // state held while the count is short
    AST_DEBOUNCE_HOLD: assert property (
      sampleStb && applyA[i] && wantA[i] != s.ch[i].alarm &&
      9'(s.ch[i].cnt) + 9'h001 < 9'(s.ch[i].cfg.debounceSampleCount)
      |=> $stable(s.ch[i].alarm) ##0 s.ch[i].cnt == $past(s.ch[i].cnt) + 8'h01)
      else $error("debounce switched early");
    // counter cleared when value returns
    AST_CNT_CLEAR: assert property (
      sampleStb && wantA[i] == s.ch[i].alarm |=> s.ch[i].cnt == 8'h00)
      else $error("debounce count not cleared");
    // limit sets above threshold with no delay
    AST_LIMIT_SET: assert property (
      sampleStb && s.ch[i].cfg.mode == FAOS_LIMIT && !s.ch[i].alarm &&
      s.ch[i].cfg.debounceSampleCount == 8'h00 && vSelA[i] > s.ch[i].thr
      |=> s.ch[i].alarm)
      else $error("limit alarm missed");
    // window sets below the lower threshold
    AST_WINDOW_LOW: assert property (
      sampleStb && s.ch[i].cfg.mode == FAOS_WINDOW && !s.ch[i].alarm &&
      s.ch[i].cfg.debounceSampleCount == 8'h00 && vSelA[i] < s.ch[i].low
      |=> s.ch[i].alarm)
      else $error("window alarm missed");
    // full scale code beyond the end value
    AST_CODE_FS: assert property (
      sampleStb && s.ch[i].cfg.typ <= FAOS_T2_10 && s.ch[i].cfg.src == FAOS_FLOW &&
      vSelA[i] >= s.ch[i].aEnd |=> analogCode[i] == `FAOS_CODE_FS)
      else $error("full scale code wrong");
    // live zero at or below the start value
    AST_CODE_LIVE: assert property (
      sampleStb && s.ch[i].cfg.typ == FAOS_T4_20 && s.ch[i].cfg.src == FAOS_TEMP &&
      vSelA[i] <= s.ch[i].aStart && vSelA[i] < s.ch[i].aEnd |=> analogCode[i] == `FAOS_CODE_LIVE)
      else $error("start code wrong");
    // volume sources refused on analogue types
    AST_BAD_SRC: assert property (
      sampleStb && s.ch[i].cfg.typ <= FAOS_T2_10 &&
      (s.ch[i].cfg.src == FAOS_VOLUME || s.ch[i].cfg.src == FAOS_PART)
      |=> analogCode[i] == `FAOS_CODE_ZERO && s.ch[i].badSrc)
      else $error("bad source not refused");

    COV_ALARM_RISE: cover property ($rose(alarmOn[i]));
    COV_DEBOUNCED: cover property (
      sampleStb && applyA[i] && s.ch[i].cnt != 8'h00 && wantA[i] != s.ch[i].alarm
      ##1 s.ch[i].alarm != $past(s.ch[i].alarm));
    COV_MID_CODE: cover property (analogCode[i] != `FAOS_CODE_FS && analogCode[i] > `FAOS_CODE_LIVE);
  end
  COV_WRITE: cover property (bvalid && bready && bresp == `FAOS_OKAY);

endmodule

// [tb/faos_monitor.sv]
// far-side monitor: resolves each alarm pin against a pull-up load
`timescale 1ns/1ns
module faos_monitor
  import faos_pkg::*;
(
  // transistor enables
  input wire logic [1:0] sinkEn,
  input wire logic [1:0] sourceEn,
  // resolved pin level and shoot-through flag
  output logic [1:0] pinLevel,
  output logic [1:0] shortHit
);
  // ======================================================================
  // pin resolution, the pull-up wins only when nothing drives
  assign pinLevel = sourceEn | ~sinkEn;
  assign shortHit = sinkEn & sourceEn;
endmodule

// [tb/tb_flow_alarm_and_output_scaling.sv]
// self-checking bench of the two-channel alarm and analogue output block
`timescale 1ns/1ns
module tb_flow_alarm_and_output_scaling
  import faos_pkg::*;
;
  logic clk, resetn, sampleStb, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, alarmOn, sinkEn, sourceEn, pinLevel, shortHit;
  logic [1:0][15:0] analogCode;
  faos_meas_s meas;
  int errCount, checkCount, seed, k;
  int cyc = 0;
  // model registers: cfg, thr, low, hys, start, end; plus alarm state and count
  longint m[2][8];
  int ast[2], cnt[2];
  logic [31:0] d;
  logic [1:0] r;

  faos_top dut (.clk, .resetn, .sampleStb, .meas, .awvalid, .awaddr, .awready, .wvalid, .wdata, .wstrb,
    .wready, .bvalid, .bresp, .bready, .arvalid, .araddr, .arready, .rvalid, .rdata, .rresp, .rready,
    .alarmOn, .sinkEn, .sourceEn, .analogCode);
  faos_monitor mon (.sinkEn, .sourceEn, .pinLevel, .shortHit);

  // ======================================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errCount++;
      endOfTest();
    end
  end

  // ======================================================================
  // compare, verdict, random
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic endOfTest();
    if (errCount == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction

  // ======================================================================
  // axi4-lite master, both channels offered together
  // waits for the answer however long it takes, only the hang guard ends a stuck wait
  task automatic wr(input logic [31:0] a, input logic [31:0] x);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  // ======================================================================
  // reference model step for one channel, then compare its outputs
  task automatic mstep(input int c, input int v);
    int n, t, s, w, dr, on, lo, code;
    n = m[c][0] >> 12 & 255;
    t = m[c][0] >> 2 & 15;
    s = m[c][0] & 3;
    dr = m[c][0] >> 8 & 3;
    v = v + (s == 1 ? 3 : s == 2 ? -3 : s == 3 ? 9 : 0);
    if (m[c][0] >> 6 & 1) w = ast[c] ? !(v > m[c][2] + m[c][3] && v < m[c][1] - m[c][3]) : v > m[c][1] || v < m[c][2];
    else w = ast[c] ? v >= m[c][1] - m[c][3] : v > m[c][1];
    if (w == ast[c]) cnt[c] = 0;
    else if (!(m[c][0] >> (w ? 10 : 11) & 1) || cnt[c] + 1 >= n) begin
      ast[c] = w;
      cnt[c] = 0;
    end
    else cnt[c]++;
    on = ast[c] ^ (m[c][0] >> 7 & 1);
    lo = (t == 0 || t == 3) ? 16'h3333 : 0;
    if (t > 3 || s % 2) code = 0;
    else if (v >= m[c][5]) code = 16'hFFFF;
    else if (v <= m[c][4]) code = lo;
    else code = lo + (v - m[c][4]) * (16'hFFFF - lo) / (m[c][5] - m[c][4]);
    chk(alarmOn[c], on);
    chk(sinkEn[c], t == 4 && (dr == 0 && on || dr == 2 && !on));
    chk(sourceEn[c], t == 4 && (dr == 1 || dr == 2) && on);
    chk(pinLevel[c], !(t == 4 && (dr == 0 && on || dr == 2 && !on)));
    chk(shortHit[c], 1'b0);
    chk(analogCode[c], code);
    rd(c * 32 + 24);
    chk(d, (t <= 3 && s % 2) << 1 | ast[c]);
    rd(c * 32 + 28);
    chk(d, code);
  endtask

  task automatic smp(input int v);
    meas <= '{flow: v, volume: v + 3, temp: v - 3, part: v + 9};
    sampleStb <= 1'b1;
    @(posedge clk);
    sampleStb <= 1'b0;
    @(posedge clk);
    mstep(0, v);
    mstep(1, v);
  endtask

  // random configuration of one channel, then read every setting back
  task automatic setup(input int c);
    int i, x;
    for (i = 0; i < 6; i++) begin
      x = i == 0 ? rnd(4) | rnd(9) << 2 | rnd(16) << 6 | rnd(4) << 10 | rnd(4) << 12 : rnd(1300) - 300;
      if (i == 3) x = rnd(40);
      wr(c * 32 + i * 4, i == 0 ? x | rnd(4096) << 20 : x);
      chk(r, 2'h0);
      if (i < 4 || i == 4 && x >= 0 && x <= 1000 || i == 5 && x > 0) m[c][i] = x;
    end
    for (i = 0; i < 6; i++) begin
      rd(c * 32 + i * 4);
      chk(d, m[c][i]);
    end
  endtask

  // ======================================================================
  // main sequence
  initial begin
    seed = 32'h9B2FC4F8;
    {resetn, sampleStb, awvalid, wvalid, arvalid} = '0;
    {bready, rready, wstrb} = 6'h3F;
    {awaddr, wdata, araddr} = '0;
    meas = '0;
    m = '{default: '{default: 0}};
    m[0][0] = 20'h00E00;
    m[1][0] = 20'h00E00;
    m[0][5] = 1000;
    m[1][5] = 1000;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 16; k++) begin
      rd(k / 8 * 32 + k % 8 * 4);
      chk(d, m[k / 8][k % 8]);
    end
    rd(32'h40);
    chk(r, 2'h2);
    chk(d, 32'h0);
    wr(32'h80, 32'h1);
    chk(r, 2'h2);
    wr(32'h18, 32'hFFFF);
    chk(r, 2'h0);
    for (k = 0; k < 60; k++) begin
      setup(rnd(2));
      repeat (10) smp(int'(rnd(2) ? m[rnd(2)][1] + rnd(60) - 30 : rnd(1400) - 300));
    end
    endOfTest();
  end
endmodule
